//--- sync_code_black_cal_formatter.sv
// output formatter: code words, black calibration, checksum and training words
// assumes pixel words arrive on CLK, link clock is asynchronous and sampled here
`timescale 1ns/1ps
`include "fmt_params.svh"

module sync_code_black_cal_formatter
    import fmt_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    input  wire logic              CLK,
    input  wire logic              RESETN,
    // classic wishbone slave
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [ADDR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK_O,
    // pixel word source
    input  wire logic              PIX_VALID,
    input  wire logic [9:0]        PIX_DATA,
    input  wire logic [2:0]        PIX_KIND,
    input  wire logic              PIX_ODD,
    output logic                   PIX_TAKEN,
    // link side
    input  wire logic              LINK_CLK,
    output logic      [9:0]        DATA_OUT,
    output logic      [9:0]        SYNC_OUT,
    output logic                   WORD_STROBE,
    output logic                   IRQ
);

    // the word index takes address bits 9:2, so a narrower bus is refused
    if (ADDR_W < 10)
    begin : g_addr_check
        $error("ADDR_W must be at least 10");
    end

    // ************************************************************
    // helper functions
    // ************************************************************

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] wdat,
                                               input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0])
            r[7:0] = wdat[7:0];
        if (sel[1])
            r[15:8] = wdat[15:8];
        return r;
    endfunction : lane_merge

    // one 10-bit word through the checksum register, msb first
    function automatic logic [9:0] crc_step(input logic [9:0] crc_in,
                                            input logic [9:0] word);
        logic [9:0] c;
        logic       fb;
        c = crc_in;
        for (int i = 9; i >= 0; i--)
        begin
            fb = c[9] ^ word[i];
            c  = {c[8:0], 1'b0} ^ (fb ? `CRC_POLY : 10'h000);
        end
        return c;
    endfunction : crc_step

    // ************************************************************
    // bus slave and registers
    // ************************************************************

    logic [15:0] dark_even_reg;
    logic [15:0] valid_even_reg;
    logic [15:0] ref_even_reg;
    logic [15:0] frame_odd_reg;
    logic [15:0] frame_even_reg;
    logic [15:0] dark_odd_reg;
    logic [15:0] valid_odd_reg;
    logic [15:0] ref_odd_reg;
    logic [15:0] checksum_reg;
    logic [15:0] align_reg;
    logic [15:0] black_cfg_reg;
    logic [15:0] calfmt_cfg_reg;
    logic [`IRQ_BITS-1:0] irq_status_reg;
    logic [`IRQ_BITS-1:0] irq_enable_reg;
    logic        cal_error_reg;
    logic [9:0]  avg_reg;

    logic        bus_req;
    logic        wr_hit;
    logic [7:0]  idx;
    logic [`IRQ_BITS-1:0] irq_clear;
    logic [`IRQ_BITS-1:0] irq_event;
    logic [15:0] rd_word;

    // request taken one cycle after it is raised; ack drops the cycle after
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_hit  = bus_req && WB_WE_I;
    assign idx     = WB_ADR_I[9:2];
    assign irq_clear = (wr_hit && idx == `IDX_IRQ_CLEAR && WB_SEL_I[0])
                       ? WB_DAT_I[`IRQ_BITS-1:0] : '0;

    // code and configuration registers
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            dark_even_reg  <= `RST_DARK;
            dark_odd_reg   <= `RST_DARK;
            valid_even_reg <= `RST_VALID;
            valid_odd_reg  <= `RST_VALID;
            ref_even_reg   <= `RST_REF;
            ref_odd_reg    <= `RST_REF;
            frame_even_reg <= `RST_FRAME;
            frame_odd_reg  <= `RST_FRAME;
            checksum_reg   <= `RST_CHECKSUM;
            align_reg      <= `RST_ALIGN;
            black_cfg_reg  <= `RST_BLACK_CFG;
            calfmt_cfg_reg <= `RST_CALFMT_CFG;
            irq_enable_reg <= '0;
        end
        else if (wr_hit)
        begin
            case (idx)
                `IDX_DARK_EVEN:  dark_even_reg  <= lane_merge(dark_even_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_DARK_ODD:   dark_odd_reg   <= lane_merge(dark_odd_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_VALID_EVEN: valid_even_reg <= lane_merge(valid_even_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_VALID_ODD:  valid_odd_reg  <= lane_merge(valid_odd_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_REF_EVEN:   ref_even_reg   <= lane_merge(ref_even_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_REF_ODD:    ref_odd_reg    <= lane_merge(ref_odd_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_FRAME_EVEN: frame_even_reg <= lane_merge(frame_even_reg, WB_DAT_I, WB_SEL_I) & 16'h007f;
                `IDX_FRAME_ODD:  frame_odd_reg  <= lane_merge(frame_odd_reg, WB_DAT_I, WB_SEL_I) & 16'h007f;
                `IDX_CHECKSUM:   checksum_reg   <= lane_merge(checksum_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_ALIGN:      align_reg      <= lane_merge(align_reg, WB_DAT_I, WB_SEL_I) & 16'h03ff;
                `IDX_BLACK_CFG:  black_cfg_reg  <= lane_merge(black_cfg_reg, WB_DAT_I, WB_SEL_I);
                `IDX_CALFMT_CFG: calfmt_cfg_reg <= lane_merge(calfmt_cfg_reg, WB_DAT_I, WB_SEL_I);
                `IDX_IRQ_ENABLE:
                begin
                    if (WB_SEL_I[0])
                        irq_enable_reg <= WB_DAT_I[`IRQ_BITS-1:0];
                end
                default: ;
            endcase
        end
    end

    // read mux; unmapped and write-only words read zero
    always_comb
    begin
        case (idx)
            `IDX_DARK_EVEN:  rd_word = dark_even_reg;
            `IDX_DARK_ODD:   rd_word = dark_odd_reg;
            `IDX_VALID_EVEN: rd_word = valid_even_reg;
            `IDX_VALID_ODD:  rd_word = valid_odd_reg;
            `IDX_REF_EVEN:   rd_word = ref_even_reg;
            `IDX_REF_ODD:    rd_word = ref_odd_reg;
            `IDX_FRAME_EVEN: rd_word = frame_even_reg;
            `IDX_FRAME_ODD:  rd_word = frame_odd_reg;
            `IDX_CHECKSUM:   rd_word = checksum_reg;
            `IDX_ALIGN:      rd_word = align_reg;
            `IDX_RSVD_SLOT:  rd_word = `RST_RSVD_SLOT;
            `IDX_BLACK_CFG:  rd_word = black_cfg_reg;
            `IDX_CALFMT_CFG: rd_word = calfmt_cfg_reg;
            `IDX_CAL_STATUS: rd_word = {15'h0000, cal_error_reg};
            `IDX_IRQ_STATUS: rd_word = {13'h0000, irq_status_reg};
            `IDX_IRQ_ENABLE: rd_word = {13'h0000, irq_enable_reg};
            `IDX_CAL_RESULT: rd_word = {6'h00, avg_reg};
            default:         rd_word = 16'h0000;
        endcase
    end

    // ack and read data from flops; every access, mapped or not, is acked once
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            WB_ACK_O <= bus_req;
            if (bus_req && !WB_WE_I)
                WB_DAT_O <= {16'h0000, rd_word};
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            irq_status_reg <= '0;
            IRQ            <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
            IRQ            <= |(((irq_status_reg & ~irq_clear) | irq_event) & irq_enable_reg);
        end
    end

    // ************************************************************
    // link clock sampling
    // ************************************************************

    logic link_meta_reg;
    logic link_sync_reg;
    logic link_prev_reg;
    logic slot;

    // two flops against metastability, a third to find the rising edge
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            link_meta_reg <= 1'b0;
            link_sync_reg <= 1'b0;
            link_prev_reg <= 1'b0;
        end
        else
        begin
            link_meta_reg <= LINK_CLK;
            link_sync_reg <= link_meta_reg;
            link_prev_reg <= link_sync_reg;
        end
    end

    assign slot = link_sync_reg && !link_prev_reg;

    // ************************************************************
    // black calibration
    // ************************************************************

    cal_state_e  cal_state_reg;
    logic [16:0] acc_reg;
    logic [7:0]  cnt_reg;
    logic [2:0]  samples_log;
    logic [7:0]  samples_need;
    logic [16:0] acc_next;
    logic        take;
    logic        is_dark;
    logic        is_frame;

    assign take        = slot && PIX_VALID;
    assign is_dark     = PIX_KIND == KIND_DARK;
    assign is_frame    = PIX_KIND == KIND_FRAME;
    assign samples_log = black_cfg_reg[`F_SAMPLES_HI:`F_SAMPLES_LO];
    assign samples_need = 8'h01 << samples_log;
    assign acc_next    = acc_reg + {7'h00, PIX_DATA};

    // averaging runs every frame; a frame word ends the sample window
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            cal_state_reg <= CAL_COLLECT;
            acc_reg       <= '0;
            cnt_reg       <= '0;
            avg_reg       <= '0;
            cal_error_reg <= 1'b0;
        end
        else if (take)
        begin
            case (cal_state_reg)
                CAL_COLLECT:
                begin
                    if (is_dark)
                    begin
                        acc_reg <= acc_next;
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg + 8'h01 == samples_need)
                        begin
                            avg_reg       <= 10'(acc_next >> samples_log);
                            cal_error_reg <= 1'b0;
                            cal_state_reg <= CAL_READY;
                        end
                    end
                    else if (is_frame)
                    begin
                        // window closed short: result is not trusted
                        cal_error_reg <= 1'b1;
                        acc_reg       <= '0;
                        cnt_reg       <= '0;
                    end
                end
                CAL_READY:
                begin
                    if (is_frame)
                    begin
                        acc_reg       <= '0;
                        cnt_reg       <= '0;
                        cal_state_reg <= CAL_COLLECT;
                    end
                end
                default:
                    cal_state_reg <= CAL_COLLECT;
            endcase
        end
    end

    assign irq_event[0] = take && cal_state_reg == CAL_COLLECT && is_dark
                          && (cnt_reg + 8'h01 == samples_need);
    assign irq_event[1] = take && cal_state_reg == CAL_COLLECT && is_frame;

    // ************************************************************
    // pixel correction
    // ************************************************************

    logic signed [12:0] corr;
    logic signed [12:0] pix_sum;
    logic [9:0]         pix_fixed;
    logic [8:0]         manual;

    assign manual = calfmt_cfg_reg[`F_MANUAL_HI:`F_MANUAL_LO];

    // signed correction, clamped to the 10-bit range at the end
    always_comb
    begin
        if (calfmt_cfg_reg[`F_AUTO_EN])
            corr = $signed({5'h00, black_cfg_reg[`F_TARGET_HI:0]})
                   - $signed({3'h0, avg_reg});
        else if (calfmt_cfg_reg[`F_MANUAL_DEC])
            corr = -$signed({4'h0, manual});
        else
            corr = $signed({4'h0, manual});
        pix_sum = $signed({3'h0, PIX_DATA}) + corr;
        if (pix_sum < 0)
            pix_fixed = 10'h000;
        else if (pix_sum > 13'sd1023)
            pix_fixed = 10'h3ff;
        else
            pix_fixed = pix_sum[9:0];
    end

    // ************************************************************
    // word formatting and checksum
    // ************************************************************

    logic [9:0] crc_reg;
    logic [9:0] seed;
    logic [9:0] data_word;
    logic [9:0] sync_word;
    logic [9:0] sync_pipe_reg [`SYNC_DELAY];

    assign seed = black_cfg_reg[`F_SEED] ? 10'h3ff : 10'h000;

    // data and code words of one slot; codes come from the registers, except the upper three frame code bits
    always_comb
    begin
        data_word = PIX_DATA;
        sync_word = PIX_ODD ? valid_odd_reg[9:0] : valid_even_reg[9:0];
        case (PIX_KIND)
            KIND_DARK:
            begin
                data_word = pix_fixed;
                sync_word = PIX_ODD ? dark_odd_reg[9:0] : dark_even_reg[9:0];
            end
            KIND_VALID:
                data_word = pix_fixed;
            KIND_REF:
            begin
                data_word = calfmt_cfg_reg[`F_REF_MODE] ? avg_reg : PIX_DATA;
                sync_word = PIX_ODD ? ref_odd_reg[9:0] : ref_even_reg[9:0];
            end
            KIND_FRAME:
                // upper three code bits travel in the pixel word
                sync_word = {PIX_DATA[9:7],
                             PIX_ODD ? frame_odd_reg[6:0] : frame_even_reg[6:0]};
            KIND_CRC:
            begin
                data_word = crc_reg;
                sync_word = checksum_reg[9:0];
            end
            default: ;
        endcase
    end

    assign irq_event[2] = take && PIX_KIND == KIND_CRC;

    // checksum over data words, restarted from the seed after it is sent and at every frame word
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            crc_reg <= 10'h000;
        else if (take && (PIX_KIND == KIND_CRC || is_frame))
            crc_reg <= seed;
        else if (take)
            crc_reg <= crc_step(crc_reg, data_word);
    end

    // code delay line, advanced once per link slot
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            for (int i = 0; i < `SYNC_DELAY; i++)
                sync_pipe_reg[i] <= 10'(`RST_ALIGN);
        end
        else if (slot)
        begin
            sync_pipe_reg[0] <= PIX_VALID ? sync_word : align_reg[9:0];
            for (int i = 1; i < `SYNC_DELAY; i++)
                sync_pipe_reg[i] <= sync_pipe_reg[i-1];
        end
    end

    // ************************************************************
    // link outputs
    // ************************************************************

    // one word per link slot; idle slots carry the training word, but with F_NARROW set SYNC_OUT gives the code word of SYNC_DELAY slots earlier
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            DATA_OUT    <= 10'(`RST_ALIGN);
            SYNC_OUT    <= 10'(`RST_ALIGN);
            WORD_STROBE <= 1'b0;
            PIX_TAKEN   <= 1'b0;
        end
        else
        begin
            WORD_STROBE <= slot;
            PIX_TAKEN   <= take;
            if (slot)
            begin
                DATA_OUT <= PIX_VALID ? data_word : align_reg[9:0];
                if (calfmt_cfg_reg[`F_NARROW])
                    SYNC_OUT <= sync_pipe_reg[`SYNC_DELAY-1];
                else
                    SYNC_OUT <= PIX_VALID ? sync_word : align_reg[9:0];
            end
        end
    end

endmodule : sync_code_black_cal_formatter

//--- fmt_params.svh
// register offsets, field positions, reset values and fixed figures of the output formatter
// assumes a 32-bit classic Wishbone slave; each register index sits at byte address 4*index
`ifndef FMT_PARAMS_SVH
`define FMT_PARAMS_SVH

// register indices (byte address = 4 * index)
`define IDX_DARK_EVEN       8'h76
`define IDX_VALID_EVEN      8'h77
`define IDX_REF_EVEN        8'h78
`define IDX_FRAME_ODD       8'h79
`define IDX_DARK_ODD        8'h7a
`define IDX_VALID_ODD       8'h7b
`define IDX_REF_ODD         8'h7c
`define IDX_CHECKSUM        8'h7d
`define IDX_ALIGN           8'h7e
`define IDX_RSVD_SLOT       8'h7f
`define IDX_BLACK_CFG       8'h80
`define IDX_CALFMT_CFG      8'h81
`define IDX_CAL_STATUS      8'h88
`define IDX_IRQ_STATUS      8'ha0
`define IDX_IRQ_ENABLE      8'ha1
`define IDX_IRQ_CLEAR       8'ha2
`define IDX_CAL_RESULT      8'ha3
`define IDX_FRAME_EVEN      8'ha4

// reset values
`define RST_DARK            16'h0015
`define RST_VALID           16'h0035
`define RST_REF             16'h0025
`define RST_FRAME           16'h002a
`define RST_CHECKSUM        16'h0059
`define RST_ALIGN           16'h03a6
`define RST_RSVD_SLOT       16'h02aa
`define RST_BLACK_CFG       16'h4008
`define RST_CALFMT_CFG      16'h0001

// field positions
`define F_TARGET_HI         7
`define F_SAMPLES_LO        8
`define F_SAMPLES_HI        10
`define F_SEED              15
`define F_AUTO_EN           0
`define F_MANUAL_LO         1
`define F_MANUAL_HI         9
`define F_MANUAL_DEC        10
`define F_NARROW            13
`define F_REF_MODE          14

// fixed figures
`define SYNC_DELAY          4
`define CRC_POLY            10'h233
`define IRQ_BITS            3

`endif

//--- fmt_pkg.sv
// types shared by the output formatter
// assumes fmt_params.svh for numeric figures
package fmt_pkg;

    // kind of word presented on the pixel input
    typedef enum logic [2:0]
    {
        KIND_DARK  = 3'h0,
        KIND_VALID = 3'h1,
        KIND_REF   = 3'h2,
        KIND_FRAME = 3'h3,
        KIND_CRC   = 3'h4
    } word_kind_e;

    // black calibration states, one-hot
    typedef enum logic [1:0]
    {
        CAL_COLLECT = 2'b01,
        CAL_READY   = 2'b10
    } cal_state_e;

endpackage : fmt_pkg

//--- fmt_assertions.sv
// checker for the output formatter, watching only its top-level ports
// assumes one clock domain on CLK with synchronous active-low RESETN
`timescale 1ns/1ps
module fmt_checker
(
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        PIX_VALID,
    input wire logic        PIX_TAKEN,
    input wire logic [9:0]  DATA_OUT,
    input wire logic [9:0]  SYNC_OUT,
    input wire logic        WORD_STROBE
);
    // ****************************************
    // bus and word stream relations
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_ack_next_cycle: assert property ($rose(WB_STB_I) && WB_CYC_I |=> WB_ACK_O)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_rdata_upper_zero: assert property (WB_DAT_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_rdata_holds: assert property ($changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I)
        else $error("read data moved outside a read");
    // one word per link period, so strobes are well apart
    a_strobe_gap: assert property (WORD_STROBE |=> !WORD_STROBE [*5])
        else $error("word strobes too close");
    a_taken_with_word: assert property (PIX_TAKEN |-> WORD_STROBE)
        else $error("pixel taken without word");
    a_taken_needs_valid: assert property (PIX_TAKEN |-> $past(PIX_VALID))
        else $error("pixel taken while none offered");
    a_word_stands: assert property (!WORD_STROBE |-> $stable(DATA_OUT) && $stable(SYNC_OUT))
        else $error("word changed between slots");
endmodule : fmt_checker

bind sync_code_black_cal_formatter fmt_checker u_chk (.CLK(CLK), .RESETN(RESETN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .PIX_VALID(PIX_VALID), .PIX_TAKEN(PIX_TAKEN),
    .DATA_OUT(DATA_OUT), .SYNC_OUT(SYNC_OUT), .WORD_STROBE(WORD_STROBE));

//--- fmt_receiver.sv
// receiver model: makes the link clock and counts words carrying the programmed dark code
// assumes each word is marked by a one-cycle strobe on the bench clock
`timescale 1ns/1ps
module fmt_receiver
(
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic       strobe,
    input  wire logic [9:0] sync_in,
    input  wire logic [9:0] dark_code,
    output logic            link_clk,
    output logic [7:0]      n_dark
);
    // link clock stands still while no frame is running
    initial link_clk = 1'b0;
    always #160 if (run) link_clk = ~link_clk;
    // classify by the live code, a fixed constant would miss reprogramming
    initial n_dark = 8'h00;
    always @(posedge clk)
        if (strobe && sync_in == dark_code)
            n_dark <= n_dark + 8'h01;
endmodule : fmt_receiver

//--- testbench.sv
// bench: register access over wishbone, word formatting, calibration, interrupt
// assumes fmt_params.svh indices and the receiver model making the link clock
`timescale 1ns/1ps
`include "fmt_params.svh"
module testbench
    import fmt_pkg::*;
;
    logic clk, rst_n, cyc, stb, we, pv, po, run, ack, taken, strobe, irq, lclk;
    logic [9:0] adr, pd, dout, sout, dcode;
    logic [31:0] dat, q, dat_o;
    logic [2:0] pk;
    logic [7:0] n_dark;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [15:0] RV [12] = '{16'h0015, 16'h0035, 16'h0025, 16'h002a, 16'h0015,
        16'h0035, 16'h0025, 16'h0059, 16'h03a6, 16'h02aa, 16'h4008, 16'h0001};
    sync_code_black_cal_formatter uut (.CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PIX_VALID(pv), .PIX_DATA(pd), .PIX_KIND(pk),
        .PIX_ODD(po), .PIX_TAKEN(taken), .LINK_CLK(lclk), .DATA_OUT(dout),
        .SYNC_OUT(sout), .WORD_STROBE(strobe), .IRQ(irq));
    fmt_receiver rx (.clk(clk), .run(run), .strobe(strobe), .sync_in(sout),
        .dark_code(dcode), .link_clk(lclk), .n_dark(n_dark));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // classic cycle: hold everything until ack is sampled high
    task wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rd(input logic [7:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 16'h0000);
        chk($sformatf("reg %h", idx), q, e);
    endtask : rd
    // offer one word, hold it until taken
    task send(input logic [2:0] k, input logic [9:0] d);
        @(posedge clk);
        pv <= 1'b1;
        pk <= k;
        pd <= d;
        do @(posedge clk); while (taken !== 1'b1);
        pv <= 1'b0;
    endtask : send
    task idle_word;
        do @(posedge clk); while (strobe !== 1'b1);
    endtask : idle_word
    initial
    begin
        {cyc, stb, we, pv, po, run, rst_n} = 7'h00;
        {adr, pd, pk, dat} = '0;
        dcode = 10'h015;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b1;
        for (int i = 0; i < 12; i++)
            rd(8'(8'h76 + i), {16'h0000, RV[i]});
        rd(`IDX_FRAME_EVEN, 32'h02a);
        $display("reset values done");
        wb(1'b1, `IDX_DARK_EVEN, 16'hffff);
        dcode <= 10'h3ff;
        rd(`IDX_DARK_EVEN, 32'h3ff);
        wb(1'b1, `IDX_FRAME_ODD, 16'hffff);
        rd(`IDX_FRAME_ODD, 32'h7f);
        wb(1'b1, `IDX_RSVD_SLOT, 16'h0000);
        rd(`IDX_RSVD_SLOT, 32'h2aa);
        rd(8'h00, 32'h0);
        $display("field widths done");
        wb(1'b1, `IDX_CALFMT_CFG, 16'h000a);
        send(KIND_DARK, 10'h100);
        chk("data", dout, 32'h105);
        chk("sync", sout, 32'h3ff);
        wb(1'b1, `IDX_CALFMT_CFG, 16'h040a);
        send(KIND_VALID, 10'h100);
        chk("data", dout, 32'h0fb);
        chk("sync", sout, 32'h035);
        send(KIND_VALID, 10'h002);
        chk("data clamp", dout, 32'h0);
        $display("manual offset done");
        idle_word();
        chk("idle", dout, 32'h3a6);
        wb(1'b1, `IDX_ALIGN, 16'h0155);
        idle_word();
        idle_word();
        chk("idle new", dout, 32'h155);
        chk("rx dark", n_dark, 32'h1);
        $display("training done");
        wb(1'b1, `IDX_CALFMT_CFG, 16'h0001);
        // the manual-stage dark word already closed a window; clear and reopen it
        wb(1'b1, `IDX_IRQ_CLEAR, 16'h0007);
        send(KIND_FRAME, 10'h000);
        wb(1'b1, `IDX_IRQ_ENABLE, 16'h0007);
        send(KIND_DARK, 10'h040);
        repeat (3) @(posedge clk);
        rd(`IDX_IRQ_STATUS, 32'h1);
        chk("irq", irq, 32'h1);
        rd(`IDX_CAL_RESULT, 32'h040);
        wb(1'b1, `IDX_IRQ_ENABLE, 16'h0000);
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 32'h0);
        wb(1'b1, `IDX_IRQ_CLEAR, 16'h0001);
        rd(`IDX_IRQ_STATUS, 32'h0);
        send(KIND_DARK, 10'h050);
        chk("auto data", dout, 32'h018);
        send(KIND_FRAME, 10'h000);
        chk("frame sync", sout, 32'h02a);
        send(KIND_CRC, 10'h000);
        chk("crc sync", sout, 32'h059);
        chk("crc zero seed", dout, 32'h000);
        send(KIND_FRAME, 10'h000);
        repeat (3) @(posedge clk);
        rd(`IDX_IRQ_STATUS, 32'h6);
        rd(`IDX_CAL_STATUS, 32'h1);
        $display("calibration done");
        wb(1'b1, `IDX_BLACK_CFG, 16'hc108);
        send(KIND_FRAME, 10'h000);
        send(KIND_CRC, 10'h000);
        chk("crc one seed", dout, 32'h3ff);
        send(KIND_DARK, 10'h040);
        send(KIND_DARK, 10'h060);
        rd(`IDX_CAL_RESULT, 32'h050);
        rd(`IDX_CAL_STATUS, 32'h0);
        wb(1'b1, `IDX_CALFMT_CFG, 16'h4001);
        send(KIND_REF, 10'h123);
        chk("ref avg", dout, 32'h050);
        chk("ref sync", sout, 32'h025);
        $display("seed, averaging and reference done");
        po <= 1'b1;
        send(KIND_DARK, 10'h000);
        chk("odd dark sync", sout, 32'h015);
        send(KIND_FRAME, 10'h380);
        chk("odd frame sync", sout, 32'h3ff);
        wb(1'b1, `IDX_CALFMT_CFG, 16'h2001);
        repeat (4) idle_word();
        send(KIND_VALID, 10'h100);
        chk("narrow early", sout, 32'h155);
        repeat (3) idle_word();
        chk("narrow held", sout, 32'h155);
        idle_word();
        chk("narrow late", sout, 32'h035);
        $display("odd kernel and narrow done");
        stop_test();
    end
endmodule : testbench
